// ==== hw/rssd_pkg.sv ====
// shared constants, types and decode helpers of the rotate/subtract/skip datapath
// ============================================================
// Operation
// - rotate left via carry into w: carry to bit 0, bit 7 to carry
// - rotate right in memory, bit 0 into bit 7, no flag changes
// - rotate right into w only, memory kept, no flag changes
// - rotate right via carry: carry to bit 7, bit 0 to carry
// - subtract with borrow: w minus operand minus inverted carry, to w or memory
// - after any subtract carry is 0 when negative, 1 when zero or positive
// - subtracts update overflow, zero, half carry, carry, signed and wide-null flags
// - plain subtract: w minus memory or immediate, carry ignored, to w or memory
// - decrement by 1 and skip next when zero; w form keeps memory
// - increment by 1 and skip next when zero; w form keeps memory
// - skip-type instructions take two cycles; a taken skip drops the next one
// - set-all writes all ones to memory, no flag changes
// - set-bit forces one selected bit to 1, keeps others, no flag changes
// - bit test skips next when selected bit is 1, no flag changes
// - skip-if-nonzero writes byte back unchanged, skips when nonzero
// - skip-if-zero skips next when the byte equals zero
// - nibble exchange swaps bits 3..0 and 7..4, to memory or w, no flags
// - skip-if-zero writes byte back unchanged, no flags, two cycles
`default_nettype none
package rssd_pkg;
	// ============================================================
	// register map, byte addresses, one word each
	localparam logic [7:0] A_WREG = 8'h00; // working register
	localparam logic [7:0] A_MEMB = 8'h04; // addressed memory byte
	localparam logic [7:0] A_IMMB = 8'h08; // immediate operand
	localparam logic [7:0] A_STAT = 8'h0c; // status flags
	localparam logic [7:0] A_CMD = 8'h10; // opcode and bit select
	localparam logic [7:0] A_RSLT = 8'h14; // skip and busy, read only
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] ONE = 8'h01;
	// ============================================================
	// types
	typedef struct packed {
		logic cz;
		logic sc;
		logic ov;
		logic z;
		logic ac;
		logic c;
	} rssd_flags_t;
	localparam rssd_flags_t FLAGS_RST = 6'h00;
	typedef enum logic [4:0] {
		OP_RLC_W = 5'h00, OP_RR = 5'h01, OP_RR_W = 5'h02,
		OP_RRC = 5'h03, OP_RRC_W = 5'h04, OP_SBC_MEM = 5'h05,
		OP_SBC_IMM = 5'h06, OP_SBC_TOM = 5'h07, OP_SUB_MEM = 5'h08,
		OP_SUB_IMM = 5'h09, OP_SUB_TOM = 5'h0a, OP_DSZ = 5'h0b,
		OP_DSZ_W = 5'h0c, OP_ISZ = 5'h0d, OP_ISZ_W = 5'h0e,
		OP_SET = 5'h0f, OP_SET_BIT = 5'h10, OP_SKB = 5'h11,
		OP_SK_NZ = 5'h12, OP_SK_Z = 5'h13, OP_NIB = 5'h14,
		OP_NIB_W = 5'h15
	} rssd_op_t;
	typedef struct packed {
		logic [2:0] bsel;
		rssd_op_t op;
	} rssd_cmd_t;
	localparam rssd_cmd_t CMD_RST = 8'h00;
	typedef struct packed {
		logic [7:0] w;
		logic [7:0] m;
		rssd_flags_t f;
		logic skip;
	} rssd_res_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_EXEC = 3'h2,
		ST_SECOND = 3'h4
	} rssd_state_t;
	// ============================================================
	// opcode classes
	function automatic logic is_sub(input rssd_op_t op);
		return op inside {OP_SBC_MEM, OP_SBC_IMM, OP_SBC_TOM,
			OP_SUB_MEM, OP_SUB_IMM, OP_SUB_TOM};
	endfunction : is_sub
	function automatic logic is_borrow(input rssd_op_t op);
		return op inside {OP_SBC_MEM, OP_SBC_IMM, OP_SBC_TOM};
	endfunction : is_borrow
	function automatic logic uses_imm(input rssd_op_t op);
		return op inside {OP_SBC_IMM, OP_SUB_IMM};
	endfunction : uses_imm
	function automatic logic is_skip(input rssd_op_t op);
		return op inside {OP_DSZ, OP_DSZ_W, OP_ISZ, OP_ISZ_W,
			OP_SKB, OP_SK_NZ, OP_SK_Z};
	endfunction : is_skip
endpackage : rssd_pkg
`default_nettype wire

// ==== hw/rssd_alu.sv ====
// combinational result and flag logic for one instruction
`default_nettype none
module rssd_alu (
	input wire rssd_pkg::rssd_cmd_t cmd_i,
	input wire logic [7:0] w_i,
	input wire logic [7:0] m_i,
	input wire logic [7:0] imm_i,
	input wire rssd_pkg::rssd_flags_t f_i,
	output rssd_pkg::rssd_res_t res_o
);
	import rssd_pkg::*;

	logic [7:0] opnd;
	logic brw;
	logic [8:0] diff;
	logic [4:0] ldiff;
	logic ovf;
	logic [7:0] dec;
	logic [7:0] inc;

	// subtract path, 9 bits so bit 8 is the borrow out
	assign opnd = uses_imm(cmd_i.op) ? imm_i : m_i;
	assign brw = is_borrow(cmd_i.op) & ~f_i.c;
	assign diff = {1'b0, w_i} - {1'b0, opnd} - {8'h00, brw};
	assign ldiff = {1'b0, w_i[3:0]} - {1'b0, opnd[3:0]} - {4'h0, brw};
	assign ovf = (w_i[7] ^ opnd[7]) & (w_i[7] ^ diff[7]);
	assign dec = m_i - ONE;
	assign inc = m_i + ONE;

	// per-opcode result; untouched fields pass through
	always_comb begin
		res_o = '{w: w_i, m: m_i, f: f_i, skip: 1'b0};
		case (cmd_i.op)
			OP_RLC_W: begin
				res_o.w = {m_i[6:0], f_i.c};
				res_o.f.c = m_i[7];
			end
			OP_RR: res_o.m = {m_i[0], m_i[7:1]};
			OP_RR_W: res_o.w = {m_i[0], m_i[7:1]};
			OP_RRC: begin
				res_o.m = {f_i.c, m_i[7:1]};
				res_o.f.c = m_i[0];
			end
			OP_RRC_W: begin
				res_o.w = {f_i.c, m_i[7:1]};
				res_o.f.c = m_i[0];
			end
			OP_SBC_MEM, OP_SBC_IMM, OP_SUB_MEM, OP_SUB_IMM: begin
				res_o.w = diff[7:0];
			end
			OP_SBC_TOM, OP_SUB_TOM: res_o.m = diff[7:0];
			OP_DSZ: begin
				res_o.m = dec;
				res_o.skip = (dec == BYTE_RST);
			end
			OP_DSZ_W: begin
				res_o.w = dec;
				res_o.skip = (dec == BYTE_RST);
			end
			OP_ISZ: begin
				res_o.m = inc;
				res_o.skip = (inc == BYTE_RST);
			end
			OP_ISZ_W: begin
				res_o.w = inc;
				res_o.skip = (inc == BYTE_RST);
			end
			OP_SET: res_o.m = ALL_ONES;
			OP_SET_BIT: res_o.m = m_i | (ONE << cmd_i.bsel);
			OP_SKB: res_o.skip = m_i[cmd_i.bsel];
			OP_SK_NZ: res_o.skip = (m_i != BYTE_RST);
			OP_SK_Z: res_o.skip = (m_i == BYTE_RST);
			OP_NIB: res_o.m = {m_i[3:0], m_i[7:4]};
			OP_NIB_W: res_o.w = {m_i[3:0], m_i[7:4]};
			default: res_o.skip = 1'b0;
		endcase
		// six subtract flags
		if (is_sub(cmd_i.op)) begin
			res_o.f.c = ~diff[8];
			res_o.f.ac = ~ldiff[4];
			res_o.f.z = (diff[7:0] == BYTE_RST);
			res_o.f.ov = ovf;
			res_o.f.sc = diff[7] ^ ovf;
			res_o.f.cz = (diff[7:0] == BYTE_RST) & (f_i.cz | ~is_borrow(cmd_i.op));
		end
	end
endmodule : rssd_alu
`default_nettype wire

// ==== hw/rssd_top.sv ====
// apb-reached rotate/subtract/skip datapath with skip sequencing
//
// The address map and the APB register port were decided locally.
`default_nettype none
module rssd_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic busy_o,
	output logic squash_o
);
	import rssd_pkg::*;

	// ============================================================
	// state
	logic [7:0] w_q;
	logic [7:0] m_q;
	logic [7:0] imm_q;
	rssd_flags_t flag_q;
	rssd_cmd_t cmd_q;
	logic skip_q;
	logic busy_q;
	logic squash_q;
	rssd_state_t state_q;
	rssd_state_t state_d;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	rssd_res_t res;

	// ============================================================
	// apb decode
	logic acc_s;
	logic done_s;
	logic wr_s;
	logic mapped_s;
	logic idle_s;
	logic [31:0] rd_s;

	// first access cycle, answered one cycle later
	assign acc_s = psel_i & penable_i & ~pready_q;
	// edge where the master sees pready high
	assign done_s = psel_i & penable_i & pready_q;
	assign idle_s = (state_q == ST_IDLE);
	assign wr_s = done_s & pwrite_i & ~pslverr_q & idle_s;
	assign mapped_s = paddr_i inside {A_WREG, A_MEMB, A_IMMB, A_STAT, A_CMD, A_RSLT};

	// read mux, narrow fields in the low bits
	always_comb begin
		rd_s = 32'h0000_0000;
		case (paddr_i)
			A_WREG: rd_s = {24'h00_0000, w_q};
			A_MEMB: rd_s = {24'h00_0000, m_q};
			A_IMMB: rd_s = {24'h00_0000, imm_q};
			A_STAT: rd_s = {26'h000_0000, flag_q};
			A_CMD: rd_s = {24'h00_0000, cmd_q};
			A_RSLT: rd_s = {30'h0000_0000, busy_q, skip_q};
			default: rd_s = 32'h0000_0000;
		endcase
	end

	// one wait state on every transfer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= acc_s;
		end
	end

	// error flag for unmapped addresses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= acc_s & ~mapped_s;
		end
	end

	// read data captured with the answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prdata_q <= 32'h0000_0000;
		end else if (acc_s) begin
			prdata_q <= pwrite_i ? 32'h0000_0000 : rd_s;
		end
	end

	// ============================================================
	// datapath
	rssd_alu u_alu (
		.cmd_i(cmd_q),
		.w_i(w_q),
		.m_i(m_q),
		.imm_i(imm_q),
		.f_i(flag_q),
		.res_o(res)
	);

	// working register: software in idle, result in exec
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			w_q <= BYTE_RST;
		end else if (state_q == ST_EXEC) begin
			w_q <= res.w;
		end else if (wr_s && paddr_i == A_WREG) begin
			w_q <= pwdata_i[7:0];
		end
	end

	// memory byte, written back on exec
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			m_q <= BYTE_RST;
		end else if (state_q == ST_EXEC) begin
			m_q <= res.m;
		end else if (wr_s && paddr_i == A_MEMB) begin
			m_q <= pwdata_i[7:0];
		end
	end

	// immediate operand
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			imm_q <= BYTE_RST;
		end else if (wr_s && paddr_i == A_IMMB) begin
			imm_q <= pwdata_i[7:0];
		end
	end

	// status flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= FLAGS_RST;
		end else if (state_q == ST_EXEC) begin
			flag_q <= res.f;
		end else if (wr_s && paddr_i == A_STAT) begin
			flag_q <= pwdata_i[5:0];
		end
	end

	// command latch, a write here starts execution
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_q <= CMD_RST;
		end else if (wr_s && paddr_i == A_CMD) begin
			cmd_q <= pwdata_i[7:0];
		end
	end

	// ============================================================
	// sequencing: exec, then a second cycle for skip types
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (wr_s && paddr_i == A_CMD) begin
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: state_d = is_skip(cmd_q.op) ? ST_SECOND : ST_IDLE;
			ST_SECOND: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// busy mirrors the next state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= (state_d != ST_IDLE);
		end
	end

	// skip outcome, kept until the next exec
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			skip_q <= 1'b0;
		end else if (state_q == ST_EXEC) begin
			skip_q <= res.skip;
		end
	end

	// squash the next fetch during the dummy cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			squash_q <= 1'b0;
		end else begin
			squash_q <= (state_q == ST_EXEC) & is_skip(cmd_q.op) & res.skip;
		end
	end

	// outputs straight from flops
	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign busy_o = busy_q;
	assign squash_o = squash_q;

	// ============================================================
	// checks
	logic [7:0] pw_q;
	logic [7:0] pm_q;
	rssd_flags_t pf_q;
	logic [7:0] chk_opnd;
	logic [8:0] chk_diff;

	// previous-cycle copies
	always_ff @(posedge clk_i) begin
		pw_q <= w_q;
		pm_q <= m_q;
		pf_q <= flag_q;
	end

	// expected subtract from the exec-cycle values
	assign chk_opnd = uses_imm(cmd_q.op) ? imm_q : pm_q;
	assign chk_diff = {1'b0, pw_q} - {1'b0, chk_opnd} - {8'h00, is_borrow(cmd_q.op) & ~pf_q.c};

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence ex_s(rssd_op_t o);
		state_q == ST_EXEC && cmd_q.op == o;
	endsequence

	sequence keep_s;
		flag_q == pf_q && m_q == pm_q;
	endsequence

	rlc_to_w_a: assert property (
		ex_s(OP_RLC_W) |=> w_q == {pm_q[6:0], pf_q.c} && m_q == pm_q
			&& flag_q.c == pm_q[7])
		else $error("rotate left via carry wrong");

	rr_mem_a: assert property (
		ex_s(OP_RR) |=> m_q == {pm_q[0], pm_q[7:1]} && flag_q == pf_q)
		else $error("rotate right in memory wrong");

	rr_to_w_a: assert property (
		ex_s(OP_RR_W) |=> w_q == {pm_q[0], pm_q[7:1]} && keep_s)
		else $error("rotate right to w wrong");

	rrc_both_a: assert property (
		ex_s(OP_RRC) or ex_s(OP_RRC_W) |=> flag_q.c == pm_q[0]
			&& (w_q == {pf_q.c, pm_q[7:1]} || m_q == {pf_q.c, pm_q[7:1]}))
		else $error("rotate right via carry wrong");

	sbc_result_a: assert property (
		ex_s(OP_SBC_MEM) or ex_s(OP_SBC_IMM) |=> w_q == chk_diff[7:0]
			&& m_q == pm_q)
		else $error("subtract with borrow wrong");

	sbc_mem_a: assert property (
		ex_s(OP_SBC_TOM) |=> m_q == chk_diff[7:0] && w_q == pw_q)
		else $error("subtract with borrow to memory wrong");

	sub_carry_a: assert property (
		state_q == ST_EXEC && is_sub(cmd_q.op) |=> flag_q.c == ~chk_diff[8])
		else $error("subtract carry wrong");

	sub_flags_a: assert property (
		state_q == ST_EXEC && is_sub(cmd_q.op) |=> flag_q.z == (chk_diff[7:0] == 8'h00)
			&& flag_q.sc == (chk_diff[7] ^ flag_q.ov))
		else $error("subtract flags wrong");

	sub_plain_a: assert property (
		ex_s(OP_SUB_MEM) or ex_s(OP_SUB_IMM) or ex_s(OP_SUB_TOM)
			|=> (w_q == chk_diff[7:0] || m_q == chk_diff[7:0]))
		else $error("plain subtract wrong");

	dec_skip_a: assert property (
		ex_s(OP_DSZ) |=> m_q == pm_q - 8'h01 && skip_q == (m_q == 8'h00)
			&& flag_q == pf_q)
		else $error("decrement skip wrong");

	inc_skip_a: assert property (
		ex_s(OP_ISZ_W) |=> w_q == pm_q + 8'h01 && skip_q == (w_q == 8'h00) && keep_s)
		else $error("increment skip to w wrong");

	two_cycle_a: assert property (
		state_q == ST_EXEC && is_skip(cmd_q.op) |=> state_q == ST_SECOND
			&& busy_o && squash_o == skip_q ##1 state_q == ST_IDLE && !squash_o)
		else $error("skip sequencing wrong");

	set_all_a: assert property (
		ex_s(OP_SET) |=> m_q == 8'hff && flag_q == pf_q)
		else $error("set all wrong");

	set_bit_a: assert property (
		ex_s(OP_SET_BIT) |=> m_q == (pm_q | (8'h01 << cmd_q.bsel)) && flag_q == pf_q)
		else $error("set bit wrong");

	bit_test_a: assert property (
		ex_s(OP_SKB) |=> skip_q == pm_q[cmd_q.bsel] && keep_s)
		else $error("bit test skip wrong");

	nonzero_a: assert property (
		ex_s(OP_SK_NZ) |=> skip_q == (pm_q != 8'h00) && keep_s)
		else $error("skip if nonzero wrong");

	zero_a: assert property (
		ex_s(OP_SK_Z) |=> skip_q == (pm_q == 8'h00) && keep_s && w_q == pw_q)
		else $error("skip if zero wrong");

	nibble_a: assert property (
		ex_s(OP_NIB) |=> m_q == {pm_q[3:0], pm_q[7:4]} && flag_q == pf_q)
		else $error("nibble exchange wrong");

	keep_flags_a: assert property (
		state_q == ST_EXEC && !is_sub(cmd_q.op) |=> flag_q[5:1] == pf_q[5:1])
		else $error("unaffected flag changed");
endmodule : rssd_top
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking apb testbench of the rotate/subtract/skip datapath
`default_nettype none
module tb import rssd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// clock, reset and bus signals
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic busy_o;
	logic squash_o;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	int busy_n = 0;
	int sq_n = 0;
	// operand sets: overflow case, negative result, zero result
	logic [7:0] ws[3] = '{8'h80, 8'h00, 8'h35};
	logic [7:0] ms[3] = '{8'h01, 8'hff, 8'h00};
	logic [7:0] is[3] = '{8'h7f, 8'h00, 8'h35};
	logic [5:0] fs[3] = '{6'h21, 6'h00, 6'h3e};

	// 40 mhz clock
	always #12.5 clk_i = ~clk_i;

	rssd_top dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.busy_o(busy_o),
		.squash_o(squash_o)
	);

	// ============================================================
	// cycle ceiling, busy and squash counting
	always @(posedge clk_i) begin
		cycles++;
		if (busy_o === 1'b1) busy_n++;
		if (squash_o === 1'b1) sq_n++;
		if (cycles == 10000) begin
			mismatches++;
			test_done();
		end
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// ============================================================
	// one apb transfer: setup, access held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 20) begin
			mismatches++;
			$display("[FAIL] pready expected 1 seen 0");
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, exp, r);
	endtask : rd_chk

	// ============================================================
	// expected {two cycles, skip, flags, mem, w} of one instruction
	function automatic logic [23:0] model(input logic [4:0] op, input logic [2:0] b,
		input logic [7:0] w, input logic [7:0] m, input logic [7:0] imm, input logic [5:0] f);
		logic [7:0] ew, em, opd, r;
		logic [5:0] ef;
		logic sk, two, bin;
		logic [8:0] d;
		logic [4:0] h;
		ew = w;
		em = m;
		ef = f;
		sk = 1'b0;
		case (op)
			OP_RLC_W: begin
				ew = {m[6:0], f[0]};
				ef[0] = m[7];
			end
			OP_RR: em = {m[0], m[7:1]};
			OP_RR_W: ew = {m[0], m[7:1]};
			OP_RRC, OP_RRC_W: begin
				if (op == OP_RRC) em = {f[0], m[7:1]};
				else ew = {f[0], m[7:1]};
				ef[0] = m[0];
			end
			OP_SBC_MEM, OP_SBC_IMM, OP_SBC_TOM, OP_SUB_MEM, OP_SUB_IMM, OP_SUB_TOM: begin
				opd = (op == OP_SBC_IMM || op == OP_SUB_IMM) ? imm : m;
				bin = (op <= OP_SBC_TOM) ? ~f[0] : 1'b0;
				d = {1'b0, w} - {1'b0, opd} - 9'(bin);
				h = {1'b0, w[3:0]} - {1'b0, opd[3:0]} - 5'(bin);
				r = d[7:0];
				ef[0] = ~d[8];
				ef[1] = ~h[4];
				ef[2] = (r == 8'h00);
				ef[3] = (w[7] != opd[7]) && (r[7] != w[7]);
				ef[4] = r[7] ^ ef[3];
				ef[5] = (op <= OP_SBC_TOM) ? (ef[2] & f[5]) : ef[2];
				if (op == OP_SBC_TOM || op == OP_SUB_TOM) em = r;
				else ew = r;
			end
			OP_DSZ: em = m - 8'h01;
			OP_DSZ_W: ew = m - 8'h01;
			OP_ISZ: em = m + 8'h01;
			OP_ISZ_W: ew = m + 8'h01;
			OP_SET: em = 8'hff;
			OP_SET_BIT: em = m | (8'h01 << b);
			OP_SKB: sk = m[b];
			OP_SK_NZ: sk = (m != 8'h00);
			OP_SK_Z: sk = (m == 8'h00);
			OP_NIB: em = {m[3:0], m[7:4]};
			OP_NIB_W: ew = {m[3:0], m[7:4]};
			default: ;
		endcase
		if (op == OP_DSZ || op == OP_ISZ) sk = (em == 8'h00);
		if (op == OP_DSZ_W || op == OP_ISZ_W) sk = (ew == 8'h00);
		two = (op >= OP_DSZ && op <= OP_ISZ_W) || (op >= OP_SKB && op <= OP_SK_Z);
		return {two, sk, ef, em, ew};
	endfunction : model

	// load operands, start one instruction, wait for idle, compare everything
	task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [7:0] w,
		input logic [7:0] m, input logic [7:0] imm, input logic [5:0] f);
		logic [23:0] e;
		logic [31:0] r;
		logic er;
		int n;
		e = model(op, b, w, m, imm, f);
		n = 0;
		wr(A_WREG, {24'h0, w});
		wr(A_MEMB, {24'h0, m});
		wr(A_IMMB, {24'h0, imm});
		wr(A_STAT, {26'h0, f});
		busy_n = 0;
		sq_n = 0;
		wr(A_CMD, {24'h0, b, op});
		do begin
			apb(1'b0, A_RSLT, 32'h0, r, er);
			n++;
		end while (r[1] !== 1'b0 && n < 10);
		chk("busy cycles", e[23] ? 32'h2 : 32'h1, busy_n);
		chk("squash pulses", {31'h0, e[22]}, sq_n);
		chk("skip outcome", {31'h0, e[22]}, r);
		rd_chk("w", A_WREG, {24'h0, e[7:0]});
		rd_chk("mem", A_MEMB, {24'h0, e[15:8]});
		rd_chk("flags", A_STAT, {26'h0, e[21:16]});
	endtask : run

	// ============================================================
	// main sequence
	initial begin : main
		logic [31:0] r;
		logic er;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		// every register reads zero after reset
		for (int i = 0; i < 6; i++) begin
			rd_chk("reset value", 8'(i * 4), 32'h0);
		end
		// result register ignores writes
		wr(A_RSLT, 32'h3);
		rd_chk("result read only", A_RSLT, 32'h0);
		// unmapped address answers with an error
		apb(1'b0, 8'h18, 32'h0, r, er);
		chk("slave error", 32'h1, {31'h0, er});
		// every opcode plus one reserved code over three operand sets
		for (int k = 0; k < 3; k++) begin
			for (int op = 0; op < 23; op++) begin
				run(5'(op), 3'(k * 3), ws[k], ms[k], is[k], fs[k]);
			end
		end
		test_done();
	end
endmodule : tb
`default_nettype wire
